// File: rtl/cvop_pkg.sv
// Constants shared by the vertical overflow and preset row scan block.
package cvop_pkg;

    localparam int VW = 10;

    localparam logic [15:0] IO_MONO_INDEX   = 16'h03b4;
    localparam logic [15:0] IO_MONO_DATA    = 16'h03b5;
    localparam logic [15:0] IO_COLOUR_INDEX = 16'h03d4;
    localparam logic [15:0] IO_COLOUR_DATA  = 16'h03d5;

    localparam logic [6:0] IDX_VERT_TOTAL = 7'h06;
    localparam logic [6:0] IDX_OVERFLOW   = 7'h07;
    localparam logic [6:0] IDX_PRESET_ROW = 7'h08;

    localparam int OVF_VT8  = 0;
    localparam int OVF_VDE8 = 1;
    localparam int OVF_VSS8 = 2;
    localparam int OVF_VBS8 = 3;
    localparam int OVF_LC8  = 4;
    localparam int OVF_VT9  = 5;
    localparam int OVF_VDE9 = 6;
    localparam int OVF_VSS9 = 7;
    localparam int MSL_VBS9 = 5;
    localparam int MSL_LC9  = 6;

    localparam int PRS_PAN_LO = 5;
    localparam int PRS_PAN_HI = 6;
    localparam int PRS_ROW_HI = 4;

    localparam logic [7:0] OVF_UNPROTECTED = 8'h10;

    localparam logic [7:0] RST_VERT_TOTAL = 8'h00;
    localparam logic [7:0] RST_OVERFLOW   = 8'h00;
    localparam logic [6:0] RST_PRESET_ROW = 7'h00;
    localparam logic [6:0] RST_INDEX      = 7'h00;

    localparam logic [VW-1:0] FRAME_EXTRA_LINES = 10'h001;

    localparam logic [5:0] PAN_STEP_NINE  = 6'h09;
    localparam logic [5:0] PAN_STEP_EIGHT = 6'h08;

endpackage

// File: rtl/cvop_pan_if.sv
// Interface carrying the panning controls to the pixel shift unit.
`timescale 1ns/1ps
interface cvop_pan_if;
    logic [1:0] byte_pan;
    logic       nine_wide;
    logic       nine_dot_off;
    logic [3:0] fine_pan;
    logic [5:0] pixel_shift;

    modport ctrl (
        output byte_pan,
        output nine_wide,
        output nine_dot_off,
        output fine_pan,
        input  pixel_shift
    );

    modport unit (
        input  byte_pan,
        input  nine_wide,
        input  nine_dot_off,
        input  fine_pan,
        output pixel_shift
    );
endinterface

// File: rtl/cvop_pan.sv
// Pixel shift unit combining byte panning with fine pixel panning.
`timescale 1ns/1ps
module cvop_pan
    import cvop_pkg::*;
(
    // Clock and reset.
    input wire logic core_clk,
    input wire logic rst,
    // Panning controls and result.
    cvop_pan_if.unit pan
);

    logic [5:0] step;
    logic [5:0] coarse;
    logic [5:0] shift_q;

    always_comb begin
        if (pan.nine_wide && !pan.nine_dot_off) begin
            step = PAN_STEP_NINE;
        end else begin
            step = PAN_STEP_EIGHT;
        end
        coarse = 6'((6'(pan.byte_pan) * step));
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            shift_q <= 6'h00;
        end else begin
            shift_q <= coarse + 6'(pan.fine_pan);
        end
    end

    assign pan.pixel_shift = shift_q;

endmodule

// File: rtl/crtc_vertical_overflow_preset.sv
// Vertical timing assembly, preset row scan and split screen address control.
`timescale 1ns/1ps
module crtc_vertical_overflow_preset
    import cvop_pkg::*;
(
    // Clock and reset.
    input  wire logic        core_clk,
    input  wire logic        rst,
    // Indexed I/O port.
    input  wire logic [15:0] io_addr,
    input  wire logic        io_wr,
    input  wire logic        io_rd,
    input  wire logic [7:0]  io_wdata,
    output logic      [7:0]  io_rdata_q,
    output logic             io_rvalid_q,
    // Controls held by neighbouring controller registers.
    input  wire logic        monochrome_emulation,
    input  wire logic        group0_protect,
    input  wire logic [7:0]  vertical_display_end_low,
    input  wire logic [7:0]  vertical_sync_start_low,
    input  wire logic [7:0]  vertical_blank_start_low,
    input  wire logic [7:0]  line_compare_low,
    input  wire logic [7:0]  maximum_scan_line_register,
    input  wire logic [7:0]  start_address_high,
    input  wire logic [7:0]  start_address_low,
    input  wire logic [15:0] row_pitch,
    input  wire logic [3:0]  horizontal_pixel_panning,
    input  wire logic        nine_wide_text,
    input  wire logic        nine_dot_disable,
    // Scan line strobe from horizontal timing.
    input  wire logic        line_tick,
    // Vertical timing outputs.
    output logic [9:0]       scan_line_q,
    output logic             display_active_q,
    output logic             vsync_start_q,
    output logic             vblank_start_q,
    output logic             frame_start_q,
    output logic             addr_restart_q,
    output logic             split_active_q,
    // Fetch and panning outputs.
    output logic [15:0]      fetch_addr_q,
    output logic [4:0]       row_scan_q,
    output logic [5:0]       pixel_shift_q
);

    // Register state.
    logic [6:0]    index_q;
    logic [7:0]    vert_total_low_q;
    logic [7:0]    overflow_q;
    logic [6:0]    preset_row_q;

    // Assembled vertical values.
    logic [VW-1:0] vert_total;
    logic [VW-1:0] vert_disp_end;
    logic [VW-1:0] vert_sync_start;
    logic [VW-1:0] vert_blank_start;
    logic [VW-1:0] line_compare;

    // Port decode.
    logic          idx_hit;
    logic          dat_hit;
    logic [7:0]    read_value;

    // Line counter.
    logic [VW-1:0] next_line;
    logic [VW-1:0] frame_last_line;

    // Row and address tracking.
    logic [15:0]   row_addr_q;
    logic [4:0]    max_scan;

    // Decoded register strobes.
    logic          wr_index;
    logic          wr_total;
    logic          wr_overflow;
    logic          wr_preset;
    logic          rd_hit;

    // Matches of the next line against the assembled values.
    logic          hit_sync;
    logic          hit_blank;
    logic          hit_compare;
    logic          hit_top;
    logic          in_active;

    // Low bytes, high bits and assembled words of the five vertical values.
    logic [7:0]    vert_low [5];
    logic [1:0]    vert_high [5];
    logic [VW-1:0] vert_val [5];

    cvop_pan_if pan_bus ();

    // Returns true when the address hits the given port of the selected emulation.
    function automatic logic port_hit(
        input logic [15:0] addr,
        input logic        mono,
        input logic [15:0] mono_port,
        input logic [15:0] colour_port
    );
        if (mono) begin
            port_hit = (addr == mono_port);
        end else begin
            port_hit = (addr == colour_port);
        end
    endfunction

    assign idx_hit = port_hit(io_addr, monochrome_emulation, IO_MONO_INDEX, IO_COLOUR_INDEX);
    assign dat_hit = port_hit(io_addr, monochrome_emulation, IO_MONO_DATA, IO_COLOUR_DATA);

    // Returns true when a data port access reaches the given register index.
    function automatic logic reg_hit(
        input logic       data_port,
        input logic [6:0] index,
        input logic [6:0] target
    );
        reg_hit = data_port && (index == target);
    endfunction

    assign wr_index    = io_wr && idx_hit;
    assign wr_total    = io_wr && reg_hit(dat_hit, index_q, IDX_VERT_TOTAL);
    assign wr_overflow = io_wr && reg_hit(dat_hit, index_q, IDX_OVERFLOW);
    assign wr_preset   = io_wr && reg_hit(dat_hit, index_q, IDX_PRESET_ROW);
    assign rd_hit      = io_rd && (idx_hit || dat_hit);

    // Vertical values are formed from low bytes, overflow bits and maximum scan line bits.
    assign vert_low[0]  = vert_total_low_q;
    assign vert_low[1]  = vertical_display_end_low;
    assign vert_low[2]  = vertical_sync_start_low;
    assign vert_low[3]  = vertical_blank_start_low;
    assign vert_low[4]  = line_compare_low;
    assign vert_high[0] = {overflow_q[OVF_VT9], overflow_q[OVF_VT8]};
    assign vert_high[1] = {overflow_q[OVF_VDE9], overflow_q[OVF_VDE8]};
    assign vert_high[2] = {overflow_q[OVF_VSS9], overflow_q[OVF_VSS8]};
    assign vert_high[3] = {maximum_scan_line_register[MSL_VBS9], overflow_q[OVF_VBS8]};
    assign vert_high[4] = {maximum_scan_line_register[MSL_LC9], overflow_q[OVF_LC8]};

    for (genvar g = 0; g < 5; g++) begin : g_vert
        assign vert_val[g] = {vert_high[g], vert_low[g]};
    end

    assign vert_total       = vert_val[0];
    assign vert_disp_end    = vert_val[1];
    assign vert_sync_start  = vert_val[2];
    assign vert_blank_start = vert_val[3];
    assign line_compare     = vert_val[4];

    assign max_scan = maximum_scan_line_register[4:0];

    // Index register write.
    always_ff @(posedge core_clk) begin
        if (rst) begin
            index_q <= RST_INDEX;
        end else if (wr_index) begin
            index_q <= io_wdata[6:0];
        end
    end

    // Vertical total register write.
    always_ff @(posedge core_clk) begin
        if (rst) begin
            vert_total_low_q <= RST_VERT_TOTAL;
        end else if (wr_total && !group0_protect) begin
            vert_total_low_q <= io_wdata;
        end
    end

    // Overflow register write; only the line compare bit passes protection.
    always_ff @(posedge core_clk) begin
        if (rst) begin
            overflow_q <= RST_OVERFLOW;
        end else if (wr_overflow) begin
            if (group0_protect) begin
                overflow_q <= (overflow_q & ~OVF_UNPROTECTED)
                            | (io_wdata & OVF_UNPROTECTED);
            end else begin
                overflow_q <= io_wdata;
            end
        end
    end

    // Preset row scan register write; the top bit is not stored.
    always_ff @(posedge core_clk) begin
        if (rst) begin
            preset_row_q <= RST_PRESET_ROW;
        end else if (wr_preset) begin
            preset_row_q <= io_wdata[6:0];
        end
    end

    // Read data selection.
    always_comb begin
        read_value = 8'h00;
        if (idx_hit) begin
            read_value = {1'b0, index_q};
        end else if (dat_hit) begin
            if (index_q == IDX_VERT_TOTAL) begin
                read_value = vert_total_low_q;
            end else if (index_q == IDX_OVERFLOW) begin
                read_value = overflow_q;
            end else if (index_q == IDX_PRESET_ROW) begin
                read_value = {1'b0, preset_row_q};
            end else begin
                read_value = 8'h00;
            end
        end else begin
            read_value = 8'h00;
        end
    end

    // Read answer one cycle after the strobe.
    always_ff @(posedge core_clk) begin
        if (rst) begin
            io_rdata_q  <= 8'h00;
            io_rvalid_q <= 1'b0;
        end else begin
            io_rvalid_q <= rd_hit;
            if (rd_hit) begin
                io_rdata_q <= read_value;
            end
        end
    end

    // Next line number; the frame holds the programmed total plus two lines.
    assign frame_last_line = vert_total + FRAME_EXTRA_LINES;

    always_comb begin
        if (scan_line_q >= frame_last_line) begin
            next_line = '0;
        end else begin
            next_line = scan_line_q + 10'h001;
        end
    end

    assign hit_sync    = (next_line == vert_sync_start);
    assign hit_blank   = (next_line == vert_blank_start);
    assign hit_compare = (next_line == line_compare);
    assign hit_top     = (next_line == 10'h000);
    assign in_active   = (next_line <= vert_disp_end);

    // Scan line counter.
    always_ff @(posedge core_clk) begin
        if (rst) begin
            scan_line_q <= '0;
        end else if (line_tick) begin
            scan_line_q <= next_line;
        end
    end

    // Display enable level for the current line.
    always_ff @(posedge core_clk) begin
        if (rst) begin
            display_active_q <= 1'b0;
        end else if (line_tick) begin
            display_active_q <= in_active;
        end
    end

    // Sync, blanking and frame start pulses, one cycle after the line strobe.
    always_ff @(posedge core_clk) begin
        if (rst) begin
            vsync_start_q  <= 1'b0;
            vblank_start_q <= 1'b0;
            frame_start_q  <= 1'b0;
        end else begin
            vsync_start_q  <= line_tick && hit_sync;
            vblank_start_q <= line_tick && hit_blank;
            frame_start_q  <= line_tick && hit_top;
        end
    end

    // Address restart pulse on the line compare line.
    always_ff @(posedge core_clk) begin
        if (rst) begin
            addr_restart_q <= 1'b0;
        end else begin
            addr_restart_q <= line_tick && hit_compare;
        end
    end

    // Split screen state, set on a compare line inside the active area.
    always_ff @(posedge core_clk) begin
        if (rst) begin
            split_active_q <= 1'b0;
        end else if (line_tick) begin
            if (hit_compare) begin
                split_active_q <= in_active;
            end else if (hit_top) begin
                split_active_q <= 1'b0;
            end
        end
    end

    // Row scan count within the character row.
    always_ff @(posedge core_clk) begin
        if (rst) begin
            row_scan_q <= 5'h00;
        end else if (line_tick) begin
            if (hit_compare) begin
                row_scan_q <= 5'h00;
            end else if (hit_top) begin
                row_scan_q <= preset_row_q[PRS_ROW_HI:0];
            end else if (row_scan_q >= max_scan) begin
                row_scan_q <= 5'h00;
            end else begin
                row_scan_q <= row_scan_q + 5'h01;
            end
        end
    end

    // Row start address; the compare line restarts it at byte zero.
    always_ff @(posedge core_clk) begin
        if (rst) begin
            row_addr_q <= 16'h0000;
        end else if (line_tick) begin
            if (hit_compare) begin
                row_addr_q <= 16'h0000;
            end else if (hit_top) begin
                row_addr_q <= {start_address_high, start_address_low};
            end else if (row_scan_q >= max_scan) begin
                row_addr_q <= row_addr_q + row_pitch;
            end
        end
    end

    // Fetch address presented for the current line.
    always_ff @(posedge core_clk) begin
        if (rst) begin
            fetch_addr_q <= 16'h0000;
        end else begin
            fetch_addr_q <= row_addr_q;
        end
    end

    // Panning controls to the shift unit.
    assign pan_bus.byte_pan     = preset_row_q[PRS_PAN_HI:PRS_PAN_LO];
    assign pan_bus.nine_wide    = nine_wide_text;
    assign pan_bus.nine_dot_off = nine_dot_disable;
    assign pan_bus.fine_pan     = horizontal_pixel_panning;
    assign pixel_shift_q        = pan_bus.pixel_shift;

    cvop_pan u_pan (
        .core_clk (core_clk),
        .rst      (rst),
        .pan      (pan_bus.unit)
    );

endmodule

// File: test/cvop_checker.sv
// Port-level checker for the vertical overflow and preset row scan block.
`timescale 1ns/1ps
module cvop_checker
    import cvop_pkg::*;
(
    // Clock and reset.
    input wire logic        core_clk,
    input wire logic        rst,
    // Register port.
    input wire logic [15:0] io_addr,
    input wire logic        io_rd,
    input wire logic        io_rvalid_q,
    input wire logic        monochrome_emulation,
    // Line timing.
    input wire logic        line_tick,
    input wire logic [9:0]  scan_line_q,
    input wire logic        frame_start_q,
    input wire logic        vsync_start_q,
    input wire logic        vblank_start_q,
    input wire logic        addr_restart_q,
    input wire logic        split_active_q,
    input wire logic [15:0] fetch_addr_q,
    input wire logic [7:0]  vertical_sync_start_low,
    input wire logic [7:0]  vertical_blank_start_low,
    input wire logic [7:0]  line_compare_low,
    input wire logic [7:0]  maximum_scan_line_register
);
    logic hit;

    assign hit = (io_addr == (monochrome_emulation ? IO_MONO_DATA : IO_COLOUR_DATA))
              || (io_addr == (monochrome_emulation ? IO_MONO_INDEX : IO_COLOUR_INDEX));

    default clocking cb @(posedge core_clk); endclocking
    default disable iff (rst);

    a_read_answer: assert property (io_rd && hit |=> io_rvalid_q)
        else $error("read answer missing");
    a_read_stray: assert property (io_rvalid_q |-> $past(io_rd) && $past(hit))
        else $error("read answer without a mapped read");
    a_line_step: assert property (line_tick
        |=> scan_line_q == $past(scan_line_q) + 10'h001 || scan_line_q == 10'h000)
        else $error("scan line did not step");
    a_line_hold: assert property (!line_tick |=> $stable(scan_line_q))
        else $error("scan line moved without a tick");
    a_frame_zero: assert property (line_tick |=> frame_start_q == (scan_line_q == 10'h000))
        else $error("frame start not tied to line zero");
    a_sync_line: assert property (vsync_start_q |-> $past(line_tick)
        && scan_line_q[7:0] == vertical_sync_start_low)
        else $error("sync start on wrong line");
    a_blank_line: assert property (vblank_start_q |-> $past(line_tick)
        && scan_line_q[7:0] == vertical_blank_start_low
        && scan_line_q[9] == maximum_scan_line_register[MSL_VBS9])
        else $error("blank start on wrong line");
    a_restart_line: assert property (addr_restart_q |-> $past(line_tick)
        && scan_line_q[7:0] == line_compare_low
        && scan_line_q[9] == maximum_scan_line_register[MSL_LC9])
        else $error("address restart on wrong line");
    a_restart_fetch: assert property (addr_restart_q |=> fetch_addr_q == 16'h0000)
        else $error("fetch did not restart at zero");
    a_split_cause: assert property ($rose(split_active_q) |-> addr_restart_q)
        else $error("split began without a restart");
endmodule

bind crtc_vertical_overflow_preset cvop_checker u_chk (.core_clk, .rst, .io_addr, .io_rd,
    .io_rvalid_q, .monochrome_emulation, .line_tick, .scan_line_q, .frame_start_q,
    .vsync_start_q, .vblank_start_q, .addr_restart_q, .split_active_q, .fetch_addr_q,
    .vertical_sync_start_low, .vertical_blank_start_low, .line_compare_low,
    .maximum_scan_line_register);

// File: test/cvop_scan_partner.sv
// Behavioural scan-out partner that paces scan lines and measures frame timing.
`timescale 1ns/1ps
module cvop_scan_partner (
    // Clock, reset and pacing.
    input  wire logic       core_clk,
    input  wire logic       rst,
    input  wire logic       run,
    // Markers from the block.
    input  wire logic [9:0] scan_line_q,
    input  wire logic       display_active_q,
    input  wire logic       vsync_start_q,
    input  wire logic       vblank_start_q,
    input  wire logic       frame_start_q,
    input  wire logic       addr_restart_q,
    // Line strobe and measurements.
    output logic            line_tick,
    output logic [9:0]      frame_len,
    output logic [9:0]      active_lines,
    output logic [9:0]      vsync_line,
    output logic [9:0]      vblank_line,
    output logic [9:0]      restart_line,
    output logic [7:0]      frames
);
    logic [1:0] pace_q;
    logic [9:0] line_cnt_q;
    logic [9:0] act_cnt_q;
    logic       tick_d1_q;

    // Paces one scan line every three clocks while running.
    always_ff @(posedge core_clk) begin
        if (rst || !run) begin
            pace_q    <= 2'h0;
            line_tick <= 1'b0;
        end else begin
            pace_q    <= (pace_q == 2'h2) ? 2'h0 : pace_q + 2'h1;
            line_tick <= (pace_q == 2'h2);
        end
    end

    // Counts lines and active lines per frame and notes where markers fall.
    always_ff @(posedge core_clk) begin
        tick_d1_q <= line_tick && !rst;
        if (rst) begin
            {frame_len, active_lines, vsync_line, vblank_line, restart_line} <= '0;
            {frames, line_cnt_q, act_cnt_q} <= '0;
        end else begin
            if (tick_d1_q && frame_start_q) begin
                frame_len    <= line_cnt_q;
                active_lines <= act_cnt_q;
                frames       <= frames + 8'h01;
                line_cnt_q   <= 10'h001;
                act_cnt_q    <= {9'h000, display_active_q};
            end else if (tick_d1_q) begin
                line_cnt_q <= line_cnt_q + 10'h001;
                act_cnt_q  <= act_cnt_q + {9'h000, display_active_q};
            end
            if (vsync_start_q) vsync_line <= scan_line_q;
            if (vblank_start_q) vblank_line <= scan_line_q;
            if (addr_restart_q) restart_line <= scan_line_q;
        end
    end
endmodule

// File: test/tb.sv
// Self-checking testbench for the vertical overflow and preset row scan block.
`timescale 1ns/1ps
module tb
    import cvop_pkg::*;
;
    logic        core_clk, rst, io_wr, io_rd, io_rvalid_q, monochrome_emulation, group0_protect;
    logic        nine_wide_text, nine_dot_disable, line_tick, run, display_active_q, ok;
    logic        vsync_start_q, vblank_start_q, frame_start_q, addr_restart_q, split_active_q;
    logic [15:0] io_addr, row_pitch, fetch_addr_q, ip, dp;
    logic [7:0]  io_wdata, io_rdata_q, vertical_display_end_low, vertical_sync_start_low, v;
    logic [7:0]  vertical_blank_start_low, line_compare_low, maximum_scan_line_register, frames;
    logic [7:0]  start_address_high, start_address_low;
    logic [9:0]  scan_line_q, frame_len, active_lines, vsync_line, vblank_line, restart_line;
    logic [4:0]  row_scan_q;
    logic [5:0]  pixel_shift_q;
    logic [3:0]  horizontal_pixel_panning;
    int          errors, checks_done;

    crtc_vertical_overflow_preset dut (.core_clk, .rst, .io_addr, .io_wr, .io_rd, .io_wdata,
        .io_rdata_q, .io_rvalid_q, .monochrome_emulation, .group0_protect,
        .vertical_display_end_low, .vertical_sync_start_low, .vertical_blank_start_low,
        .line_compare_low, .maximum_scan_line_register, .start_address_high,
        .start_address_low, .row_pitch, .horizontal_pixel_panning, .nine_wide_text,
        .nine_dot_disable, .line_tick, .scan_line_q, .display_active_q, .vsync_start_q,
        .vblank_start_q, .frame_start_q, .addr_restart_q, .split_active_q, .fetch_addr_q,
        .row_scan_q, .pixel_shift_q);
    cvop_scan_partner u_mon (.core_clk, .rst, .run, .scan_line_q, .display_active_q,
        .vsync_start_q, .vblank_start_q, .frame_start_q, .addr_restart_q, .line_tick,
        .frame_len, .active_lines, .vsync_line, .vblank_line, .restart_line, .frames);

    task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
        checks_done++;
        if (seen !== exp) begin
            errors++;
            $display("Error %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic wr(input logic [15:0] a, input logic [7:0] d);
        @(posedge core_clk);
        io_addr  <= a;
        io_wdata <= d;
        io_wr    <= 1'b1;
        @(posedge core_clk);
        io_wr <= 1'b0;
    endtask

    task automatic rd(input logic [15:0] a, output logic [7:0] d, output logic okv);
        @(posedge core_clk);
        io_addr <= a;
        io_rd   <= 1'b1;
        @(posedge core_clk);
        io_rd <= 1'b0;
        @(posedge core_clk);
        okv = io_rvalid_q;
        d   = io_rdata_q;
    endtask

    task automatic cget(input logic [7:0] idx, output logic [7:0] d);
        logic okv;
        wr(ip, idx);
        rd(dp, d, okv);
    endtask

    task automatic frame_case(input logic [9:0] vt, de, vss, vbs, lc, rl);
        int k;
        run <= 1'b0;
        vertical_display_end_low   <= de[7:0];
        vertical_sync_start_low    <= vss[7:0];
        vertical_blank_start_low   <= vbs[7:0];
        line_compare_low           <= lc[7:0];
        maximum_scan_line_register <= {1'b0, lc[9], vbs[9], 5'h1f};
        wr(ip, 8'h06);
        wr(dp, vt[7:0]);
        wr(ip, 8'h07);
        wr(dp, {vss[9], de[9], vt[9], lc[8], vbs[8], vss[8], de[8], vt[8]});
        run <= 1'b1;
        k = frames + 3;
        for (int i = 0; i < 6000 && frames !== 8'(k); i++) @(posedge core_clk);
        check("frame_count", {8'h00, frames}, 16'(8'(k)));
        check("frame_len", {6'h00, frame_len}, 16'(vt + 10'h002));
        check("active_lines", {6'h00, active_lines}, 16'(de + 10'h001));
        check("vsync_line", {6'h00, vsync_line}, {6'h00, vss});
        check("vblank_line", {6'h00, vblank_line}, {6'h00, vbs});
        check("restart_line", {6'h00, restart_line}, {6'h00, rl});
        $display("test frame %h done", vt);
    endtask

    task automatic print_verdict;
        $display("checks %0d errors %0d", checks_done, errors);
        if (errors == 0 && checks_done > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    initial begin
        core_clk = 1'b0;
        forever #20 core_clk = ~core_clk;
    end

    initial begin
        repeat (40000) @(posedge core_clk);
        errors++;
        print_verdict;
    end

    initial begin
        {io_wr, io_rd, run, monochrome_emulation, group0_protect, nine_dot_disable} = '0;
        {io_addr, io_wdata, vertical_display_end_low, vertical_sync_start_low} = '0;
        {vertical_blank_start_low, line_compare_low, nine_wide_text} = '0;
        {errors, checks_done} = '0;
        maximum_scan_line_register = 8'h1f;
        start_address_high = 8'h12;
        start_address_low = 8'h34;
        row_pitch = 16'h0050;
        horizontal_pixel_panning = 4'h5;
        ip = IO_COLOUR_INDEX;
        dp = IO_COLOUR_DATA;
        rst = 1'b1;
        repeat (6) @(posedge core_clk);
        rst <= 1'b0;
        cget(8'h06, v);
        check("total_reset", {8'h00, v}, 16'h0000);
        cget(8'h07, v);
        check("overflow_reset", {8'h00, v & 8'h21}, 16'h0000);
        cget(8'h08, v);
        check("preset_reset", {8'h00, v & 8'h80}, 16'h0000);
        $display("test reset done");
        wr(ip, 8'h08);
        wr(dp, 8'hff);
        rd(dp, v, ok);
        check("preset_bit7", {8'h00, v}, 16'h007f);
        wr(ip, 8'h86);
        rd(ip, v, ok);
        check("index_read", {8'h00, v}, 16'h0006);
        cget(8'h09, v);
        check("other_index", {8'h00, v}, 16'h0000);
        rd(IO_MONO_DATA, v, ok);
        check("unmapped_read", {15'h0000, ok}, 16'h0000);
        monochrome_emulation <= 1'b1;
        ip = IO_MONO_INDEX;
        dp = IO_MONO_DATA;
        wr(ip, 8'h06);
        wr(dp, 8'h44);
        cget(8'h06, v);
        check("mono_total", {8'h00, v}, 16'h0044);
        monochrome_emulation <= 1'b0;
        ip = IO_COLOUR_INDEX;
        dp = IO_COLOUR_DATA;
        $display("test register port done");
        group0_protect <= 1'b1;
        wr(ip, 8'h06);
        wr(dp, 8'h55);
        wr(ip, 8'h07);
        wr(dp, 8'hff);
        cget(8'h06, v);
        check("protected_total", {8'h00, v}, 16'h0044);
        cget(8'h07, v);
        check("protected_overflow", {8'h00, v}, 16'h0010);
        group0_protect <= 1'b0;
        $display("test protection done");
        frame_case(10'h104, 10'h100, 10'h102, 10'h103, 10'h3ff, 10'h000);
        frame_case(10'h206, 10'h205, 10'h204, 10'h203, 10'h010, 10'h010);
        for (int i = 0; i < 2000 && frame_start_q !== 1'b1; i++) @(posedge core_clk);
        check("top_found", {15'h0000, frame_start_q}, 16'h0001);
        check("row_scan_top", {11'h000, row_scan_q}, 16'h001f);
        check("split_top", {15'h0000, split_active_q}, 16'h0000);
        @(posedge core_clk);
        check("fetch_top", fetch_addr_q, 16'h1234);
        $display("test top row done");
        run <= 1'b0;
        // Pan code times step plus fine pan, for nine-wide, nine-dot off and eight-wide modes.
        for (int m = 0; m < 12; m++) begin
            nine_wide_text   <= (m < 8);
            nine_dot_disable <= (m / 4 == 1);
            wr(ip, 8'h08);
            wr(dp, {1'b0, m[1:0], 5'h00});
            repeat (3) @(posedge core_clk);
            check("pixel_shift", {10'h000, pixel_shift_q},
                16'(m % 4 * ((m < 4) ? 9 : 8) + 5));
        end
        $display("test panning done");
        print_verdict;
    end
endmodule
